// [include/apst_params.svh]
// Offsets, field positions, reset values and timing counts of the sample timing block.
`ifndef APST_PARAMS_SVH
`define APST_PARAMS_SVH

`define APST_A_CTRL1      4'h0
`define APST_A_TRIG_EN    4'h1
`define APST_A_CTRL3      4'h2
`define APST_A_CHAN       4'h3
`define APST_A_SW_TRIG    4'h4
`define APST_A_STAT       4'h5
`define APST_A_MASK       4'h6
`define APST_A_RES_A      4'h7
`define APST_A_RES_B      4'h8
`define APST_A_PWR        4'h9

`define APST_M_CTRL1      16'h0f03
`define APST_M_TRIG_EN    16'h0007
`define APST_M_CTRL3      16'h00e0
`define APST_M_CHAN       16'h000f
`define APST_M_STAT       16'h000f
`define APST_R_TRIG_EN    16'h0007

`define APST_B_SAMPLING_MODE_SELECT      0
`define APST_B_CONT       1
`define APST_B_ACQ_LO     8
`define APST_B_ACQ_HI     11
`define APST_B_BGR1       7
`define APST_B_BGR0       6
`define APST_B_CORE       5
`define APST_B_EN_PWM     0
`define APST_B_EN_SW      1
`define APST_B_EN_EXT     2
`define APST_S_RES_A      0
`define APST_S_RES_B      1
`define APST_S_PWR        2
`define APST_S_OVR        3

`define APST_SYS_NS       4
`define APST_CONV_NS      80
`define APST_HALF_CYC     (`APST_CONV_NS / (2 * `APST_SYS_NS))
`define APST_DLY_HALF     5
`define APST_LAT_A_HALF   8
`define APST_LAT_B_HALF   10
`define APST_INT_DLY      2
`define APST_REF_MS       5
`define APST_REF_CYC      (`APST_REF_MS * 1000000 / `APST_SYS_NS)
`define APST_CORE_US      50
`define APST_CORE_CYC     (`APST_CORE_US * 1000 / `APST_SYS_NS)

`endif

// [include/apst_pkg.sv]
// Types shared by the sample timing block and its bench.
`default_nettype none

package apst_pkg;

    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_HOLD, ST_GAP} apst_state_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } apst_bus_t;

    typedef struct packed {
        logic        vld;
        logic        dual;
        logic [11:0] a;
        logic [11:0] b;
    } apst_pipe_t;

endpackage

`default_nettype wire

// [core/apst_core.sv]
// Power-up sequencing, trigger, sample/hold and result timing of the converter.
//
// Added by the designer: the strobed register port and the address map.
`include "apst_params.svh"
`default_nettype none

module apst_core
    import apst_pkg::*;
#(
    parameter int unsigned REF_SETTLE_CYC  = `APST_REF_CYC,
    parameter int unsigned CORE_SETTLE_CYC = `APST_CORE_CYC
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // Register port
    input  wire apst_bus_t   bus_i,
    output logic [15:0]      rdata_o,
    // Trigger sources
    input  wire logic        pwm_event_source_i,
    input  wire logic        external_start_conversion_i,
    // Analog front end
    input  wire logic [11:0] code_a_i,
    input  wire logic [11:0] code_b_i,
    output logic [3:0]       sel_a_o,
    output logic [3:0]       sel_b_o,
    output logic             sample_hold_o,
    output logic             converter_clock_o,
    // Interrupt
    output logic             irq_o
);

    localparam int H = `APST_HALF_CYC;
    localparam int LAT_A = `APST_LAT_A_HALF * H;
    localparam int LAT_B = `APST_LAT_B_HALF * H;
    localparam int DMIN = `APST_DLY_HALF * H + 2;
    localparam int DMAX = (`APST_DLY_HALF + 1) * H + 1;
    localparam int NPIPE = `APST_LAT_B_HALF;
    // The fall is seen one cycle after the sampling edge that feeds the pipeline.
    localparam int LAT_A_SEEN = LAT_A - 1;
    localparam int LAT_B_SEEN = LAT_B - 1;

    logic [15:0]      ctrl1_reg, trig_en_reg, ctrl3_reg, chan_reg;
    logic [3:0]       stat_reg, mask_reg, stat_next;
    logic [11:0]      res_a_reg, res_b_reg;
    logic [15:0]      rdata_reg;
    logic [31:0]      ref_cnt_reg, core_cnt_reg;
    logic             ref_ok, core_ok, powered, pwr_ok_q;
    logic [3:0]       half_cnt_reg;
    logic             half_tick, conv_clk_reg;
    apst_state_t      state_reg;
    logic [4:0]       cnt_reg;
    logic             sh_reg;
    apst_pipe_t       pipe_reg [NPIPE];
    logic [`APST_INT_DLY-1:0] evt_a_sr, evt_b_sr;
    logic [3:0]       sel_a_reg, sel_b_reg;
    logic [3:0]       acq;
    logic             dual, cont, sw_trig, trig_req, accept, sample_now;
    logic             upd_a, upd_b;
    logic [4:0]       hold_last, gap_last;
    logic [3:0]       acq_reg;
    logic             dual_reg;

    assign acq  = acq_reg;
    assign dual = dual_reg;
    assign cont = ctrl1_reg[`APST_B_CONT];
    assign sw_trig = bus_i.wr && bus_i.addr == `APST_A_SW_TRIG && bus_i.wdata[0];

    // Mode and acquisition width are taken when a trigger is accepted, so a
    // rewrite of control one during a burst cannot stretch or cut a pulse.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acq_reg  <= 4'h0;
            dual_reg <= 1'b0;
        end else if (accept) begin
            acq_reg  <= ctrl1_reg[`APST_B_ACQ_HI:`APST_B_ACQ_LO];
            dual_reg <= ctrl1_reg[`APST_B_SAMPLING_MODE_SELECT];
        end
    end

    // Register writes.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl1_reg   <= 16'h0000;
            trig_en_reg <= `APST_R_TRIG_EN;
            ctrl3_reg   <= 16'h0000;
            chan_reg    <= 16'h0000;
            mask_reg    <= 4'h0;
        end else if (bus_i.wr) begin
            unique case (bus_i.addr)
                `APST_A_CTRL1:   ctrl1_reg   <= bus_i.wdata & `APST_M_CTRL1;
                `APST_A_TRIG_EN: trig_en_reg <= bus_i.wdata & `APST_M_TRIG_EN;
                `APST_A_CTRL3:   ctrl3_reg   <= bus_i.wdata & `APST_M_CTRL3;
                `APST_A_CHAN:    chan_reg    <= bus_i.wdata & `APST_M_CHAN;
                `APST_A_MASK:    mask_reg    <= bus_i.wdata[3:0];
                default: ;
            endcase
        end
    end

    // Read data stand for exactly one cycle after the strobe.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= 16'h0000;
        end else if (bus_i.rd) begin
            unique case (bus_i.addr)
                `APST_A_CTRL1:   rdata_reg <= ctrl1_reg;
                `APST_A_TRIG_EN: rdata_reg <= trig_en_reg;
                `APST_A_CTRL3:   rdata_reg <= ctrl3_reg;
                `APST_A_CHAN:    rdata_reg <= chan_reg;
                `APST_A_STAT:    rdata_reg <= {12'h000, stat_reg};
                `APST_A_MASK:    rdata_reg <= {12'h000, mask_reg};
                `APST_A_RES_A:   rdata_reg <= {4'h0, res_a_reg};
                `APST_A_RES_B:   rdata_reg <= {4'h0, res_b_reg};
                `APST_A_PWR:     rdata_reg <= {13'h0000, state_reg != ST_IDLE, core_ok, ref_ok};
                default:         rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end
    assign rdata_o = rdata_reg;

    // Reference settles while both reference bits are set; the core counts only
    // behind them, so setting all three at once still waits the reference delay.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_cnt_reg  <= 32'h0000_0000;
            core_cnt_reg <= 32'h0000_0000;
            pwr_ok_q     <= 1'b0;
        end else begin
            pwr_ok_q <= powered;
            if (!(ctrl3_reg[`APST_B_BGR1] && ctrl3_reg[`APST_B_BGR0])) begin
                ref_cnt_reg <= 32'h0000_0000;
            end else if (!ref_ok) begin
                ref_cnt_reg <= ref_cnt_reg + 32'h0000_0001;
            end
            if (!ctrl3_reg[`APST_B_CORE] || !ref_ok) begin
                core_cnt_reg <= 32'h0000_0000;
            end else if (!core_ok) begin
                core_cnt_reg <= core_cnt_reg + 32'h0000_0001;
            end
        end
    end
    // Ready drops at once when software clears a power bit.
    assign ref_ok  = ref_cnt_reg >= REF_SETTLE_CYC
                  && ctrl3_reg[`APST_B_BGR1] && ctrl3_reg[`APST_B_BGR0];
    assign core_ok = core_cnt_reg >= CORE_SETTLE_CYC && ref_ok && ctrl3_reg[`APST_B_CORE];
    assign powered = ref_ok && core_ok && ctrl3_reg[`APST_B_CORE];

    // Converter clock: system clock divided, with a tick on each half period.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            half_cnt_reg <= 4'h0;
            conv_clk_reg <= 1'b0;
        end else if (half_tick) begin
            half_cnt_reg <= 4'h0;
            conv_clk_reg <= !conv_clk_reg;
        end else begin
            half_cnt_reg <= half_cnt_reg + 4'h1;
        end
    end
    assign half_tick = half_cnt_reg == 4'(H - 1);
    assign converter_clock_o = conv_clk_reg;

    assign trig_req = (pwm_event_source_i && trig_en_reg[`APST_B_EN_PWM])
                    || (sw_trig && trig_en_reg[`APST_B_EN_SW])
                    || (external_start_conversion_i && trig_en_reg[`APST_B_EN_EXT]);
    assign accept = trig_req && powered && state_reg == ST_IDLE;
    assign hold_last = {acq, 1'b1};
    assign gap_last = dual ? 5'd3 : 5'd1;
    assign sample_now = state_reg == ST_HOLD && half_tick && cnt_reg == hold_last;

    // Sequencer in converter half periods: delay, hold, optional gap.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 5'd0;
            sh_reg    <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        state_reg <= ST_DELAY;
                        cnt_reg   <= 5'd0;
                    end
                end
                ST_DELAY: begin
                    if (half_tick && cnt_reg == 5'(`APST_DLY_HALF)) begin
                        state_reg <= ST_HOLD;
                        cnt_reg   <= 5'd0;
                        sh_reg    <= 1'b1;
                    end else if (half_tick) begin
                        cnt_reg <= cnt_reg + 5'd1;
                    end
                end
                ST_HOLD: begin
                    if (sample_now) begin
                        state_reg <= (cont && powered) ? ST_GAP : ST_IDLE;
                        cnt_reg   <= 5'd0;
                        sh_reg    <= 1'b0;
                    end else if (half_tick) begin
                        cnt_reg <= cnt_reg + 5'd1;
                    end
                end
                ST_GAP: begin
                    if (half_tick && cnt_reg == gap_last) begin
                        state_reg <= ST_HOLD;
                        cnt_reg   <= 5'd0;
                        sh_reg    <= 1'b1;
                    end else if (half_tick) begin
                        cnt_reg <= cnt_reg + 5'd1;
                    end
                end
            endcase
        end
    end
    assign sample_hold_o = sh_reg;

    // Channel selects: one of sixteen, or matched pair index in both groups.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_a_reg <= 4'h0;
            sel_b_reg <= 4'h0;
        end else if (dual) begin
            sel_a_reg <= {1'b0, chan_reg[2:0]};
            sel_b_reg <= {1'b1, chan_reg[2:0]};
        end else begin
            sel_a_reg <= chan_reg[3:0];
            sel_b_reg <= chan_reg[3:0];
        end
    end
    assign sel_a_o = sel_a_reg;
    assign sel_b_o = sel_b_reg;

    // Conversion pipeline advancing each half period; samples overlap in flight.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NPIPE; i++) begin
                pipe_reg[i] <= '0;
            end
        end else if (half_tick) begin
            pipe_reg[0] <= '{vld: sample_now, dual: dual, a: code_a_i, b: code_b_i};
            for (int i = 1; i < NPIPE; i++) begin
                pipe_reg[i] <= pipe_reg[i-1];
            end
        end
    end
    assign upd_a = half_tick && pipe_reg[`APST_LAT_A_HALF-1].vld;
    assign upd_b = half_tick && pipe_reg[NPIPE-1].vld && pipe_reg[NPIPE-1].dual;

    // Result registers and the delayed flag events.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            res_a_reg <= 12'h000;
            res_b_reg <= 12'h000;
            evt_a_sr  <= '0;
            evt_b_sr  <= '0;
        end else begin
            if (upd_a) begin
                res_a_reg <= pipe_reg[`APST_LAT_A_HALF-1].a;
            end
            if (upd_b) begin
                res_b_reg <= pipe_reg[NPIPE-1].b;
            end
            evt_a_sr <= {evt_a_sr[`APST_INT_DLY-2:0], upd_a};
            evt_b_sr <= {evt_b_sr[`APST_INT_DLY-2:0], upd_b};
        end
    end

    // Sticky status, write one to clear; a new event wins over the clear.
    always_comb begin
        stat_next = stat_reg;
        if (bus_i.wr && bus_i.addr == `APST_A_STAT) begin
            stat_next = stat_reg & ~bus_i.wdata[3:0];
        end
        stat_next[`APST_S_RES_A] |= evt_a_sr[`APST_INT_DLY-1];
        stat_next[`APST_S_RES_B] |= evt_b_sr[`APST_INT_DLY-1];
        stat_next[`APST_S_PWR]   |= powered && !pwr_ok_q;
        stat_next[`APST_S_OVR]   |= trig_req && !accept;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stat_reg <= 4'h0;
        end else begin
            stat_reg <= stat_next;
        end
    end
    assign irq_o = |(stat_reg & mask_reg);

    // Helper counters watched by the checks below.
    logic [15:0] sh_len, fall_cnt;
    logic        via_gap;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sh_len   <= 16'h0000;
            fall_cnt <= 16'h0000;
            via_gap  <= 1'b0;
        end else begin
            sh_len   <= sh_reg ? sh_len + 16'h0001 : 16'h0000;
            fall_cnt <= (!sh_reg && sh_len != 16'h0000) ? 16'h0001 : fall_cnt + 16'h0001;
            if (state_reg == ST_GAP) begin
                via_gap <= 1'b1;
            end else if (state_reg == ST_IDLE) begin
                via_gap <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_trig_power_gate: assert property (accept |-> ref_ok && core_ok)
        else $error("Trigger accepted before power-up settled.");
    a_power_order: assert property (core_ok |-> ctrl3_reg[`APST_B_BGR1] && ref_ok)
        else $error("Core counted ready without settled reference.");
    a_sh_width: assert property ($fell(sh_reg) |-> sh_len == 16'((acq + 1) * 2 * H))
        else $error("Sample/hold width differs from one plus field.");
    a_trig_delay: assert property (accept |-> ##[DMIN:DMAX] $rose(sh_reg))
        else $error("Sampling did not start 2.5 clocks after trigger.");
    a_first_result_a: assert property ($fell(sh_reg) |-> ##LAT_A_SEEN upd_a)
        else $error("First A result not four clocks after sampling.");
    a_first_result_b: assert property ($fell(sh_reg) && pipe_reg[0].dual |-> ##LAT_B_SEEN upd_b)
        else $error("First B result not five clocks after sampling.");
    a_result_period: assert property ($fell(sh_reg) && via_gap && $past(state_reg) == ST_HOLD
        |-> fall_cnt == 16'((acq + (dual ? 3 : 2)) * 2 * H))
        else $error("Successive sample spacing is wrong.");
    a_flag_after_result: assert property (upd_a ##1 1 |-> ##`APST_INT_DLY stat_reg[0])
        else $error("Result flag not set after result update.");
    a_pair_select: assert property (sh_reg && dual |-> sel_b_o == {1'b1, sel_a_o[2:0]})
        else $error("Simultaneous mode pair indices differ.");
    a_refused_flag: assert property (trig_req && !accept |-> ##1 stat_reg[`APST_S_OVR])
        else $error("Refused trigger did not set its flag.");
    a_idle_no_pulse: assert property (state_reg == ST_IDLE |-> !sh_reg)
        else $error("Sample/hold pulse high while idle.");
    a_stat_clear: assert property (bus_i.wr && bus_i.addr == `APST_A_STAT && bus_i.wdata[0] && !evt_a_sr[`APST_INT_DLY-1] |-> ##1 !stat_reg[0])
        else $error("Result flag not cleared by write of one.");

    c_seq_conv: cover property ($fell(sh_reg) && !dual ##LAT_A_SEEN upd_a);
    c_sim_conv: cover property ($fell(sh_reg) && dual ##LAT_B_SEEN upd_b);
    c_continuous: cover property (state_reg == ST_GAP ##[1:200] $rose(sh_reg));
    c_refused: cover property (trig_req && !accept);
    c_dual_stream: cover property (state_reg == ST_GAP && dual ##[1:200] $rose(sh_reg));

endmodule // apst_core

`default_nettype wire

// [sim/apst_front_model.sv]
// Analog front end and trigger sources facing the sample timing block.
`default_nettype none

module apst_front_model (
    // Bench control
    input  wire logic [7:0]  level_i,
    input  wire logic        fire_pwm_i,
    input  wire logic        fire_ext_i,
    // Channel side
    input  wire logic [3:0]  sel_a_i,
    input  wire logic [3:0]  sel_b_i,
    output logic [11:0]      code_a_o,
    output logic [11:0]      code_b_o,
    // Trigger side
    output logic             pwm_o,
    output logic             ext_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Each input reads back its own index, so a wrong select shows in the result.
    assign code_a_o = {sel_a_i, level_i};
    assign code_b_o = {sel_b_i, level_i};
    assign pwm_o    = fire_pwm_i;
    assign ext_o    = fire_ext_i;
endmodule // apst_front_model

`default_nettype wire

// [sim/apst_tb_top.sv]
// Self-checking bench of the converter power-up and sample timing block.
`include "apst_params.svh"
`default_nettype none

module adc_powerup_and_sample_timing_tb_top import apst_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int REF  = 200;
    localparam int CORE = 50;

    logic        clk_i, rstn_i, fire_pwm, fire_ext, pwm, ext, sh, irq;
    apst_bus_t   bus;
    logic [15:0] rdata, d;
    logic [11:0] code_a, code_b;
    logic [3:0]  sel_a, sel_b;
    logic [7:0]  level;
    int          fail_count, checked;
    int          exp_q[$];

    apst_core #(.REF_SETTLE_CYC(REF), .CORE_SETTLE_CYC(CORE)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus), .rdata_o(rdata),
        .pwm_event_source_i(pwm), .external_start_conversion_i(ext),
        .code_a_i(code_a), .code_b_i(code_b), .sel_a_o(sel_a), .sel_b_o(sel_b),
        .sample_hold_o(sh), .converter_clock_o(), .irq_o(irq));

    apst_front_model model (
        .level_i(level), .fire_pwm_i(fire_pwm), .fire_ext_i(fire_ext),
        .sel_a_i(sel_a), .sel_b_i(sel_b), .code_a_o(code_a), .code_b_o(code_b),
        .pwm_o(pwm), .ext_o(ext));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic results();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_in(input int n, input int lo, input int hi);
        checked++;
        if (n < lo || n > hi) begin
            fail_count++;
            $display("[ERR] %0t count %0d outside %0d..%0d", $time, n, lo, hi);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_i);
        bus.addr  <= a;
        bus.wdata <= v;
        bus.wr    <= 1'b1;
        @(posedge clk_i);
        bus.wr    <= 1'b0;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clk_i);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk_i);
        bus.rd   <= 1'b0;
        #1;
        check(rdata & m, e);
    endtask

    // Counts edges until the watched output reaches the wanted level.
    task automatic wait_for(input bit use_irq, input logic v, input int lim, inout int n);
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
            k++;
        end while ((use_irq ? irq : sh) !== v && k < lim);
        if ((use_irq ? irq : sh) !== v) begin
            fail_count++;
            $display("[ERR] %0t wait ran out", $time);
            results();
        end
    endtask

    task automatic fire(input int src);
        if (src == 1) begin
            wr(`APST_A_SW_TRIG, 16'h0001);
        end else begin
            @(posedge clk_i);
            fire_pwm <= (src == 0);
            fire_ext <= (src == 2);
            @(posedge clk_i);
            fire_pwm <= 1'b0;
            fire_ext <= 1'b0;
        end
    endtask

    task automatic convert(input int src, input int acq, input bit dual, input int ch);
        int n;
        logic [3:0] ea, eb;
        n  = 0;
        ea = dual ? {1'b0, 3'(ch)} : 4'(ch);
        eb = dual ? {1'b1, 3'(ch)} : 4'(ch);
        @(posedge clk_i);
        level <= 8'($urandom);
        wr(`APST_A_CTRL1, {4'h0, 4'(acq), 7'h00, dual});
        wr(`APST_A_CHAN, 16'(ch));
        wr(`APST_A_MASK, dual ? 16'h0003 : 16'h0001);
        fire(src);
        wait_for(0, 1, 100, n);
        check_in(n, 50, 62);
        n = 0;
        wait_for(0, 0, 400, n);
        check_in(n, 20 * (1 + acq), 20 * (1 + acq));
        check({8'h00, sel_a, sel_b}, {8'h00, ea, eb});
        exp_q.push_back({ea, level});
        if (dual) exp_q.push_back({eb, level});
        n = 0;
        wait_for(1, 1, 120, n);
        check_in(n, 80, 85);
        wr(`APST_A_STAT, 16'h0001);
        n += 2;
        if (dual) begin
            wait_for(1, 1, 60, n);
            check_in(n, 100, 105);
        end
        rdc(`APST_A_RES_A, 16'(exp_q.pop_front()), 16'hffff);
        if (dual) rdc(`APST_A_RES_B, 16'(exp_q.pop_front()), 16'hffff);
        wr(`APST_A_STAT, 16'h000f);
        $display("conversion src %0d acq %0d dual %0d done", src, acq, dual);
    endtask

    task automatic stream(input int acq, input bit dual);
        int n;
        n = 0;
        wr(`APST_A_CTRL1, {4'h0, 4'(acq), 6'h00, 1'b1, dual});
        fire(0);
        wait_for(0, 1, 100, n);
        wr(`APST_A_SW_TRIG, 16'h0001);
        rdc(`APST_A_STAT, 16'h0008, 16'h0008);
        wait_for(0, 0, 400, n);
        n = 0;
        wait_for(0, 1, 200, n);
        wait_for(0, 0, 400, n);
        check_in(n, 20 * (2 + acq + dual), 20 * (2 + acq + dual));
        wr(`APST_A_CTRL1, 16'h0000);
        wait_for(0, 1, 100, n);
        wait_for(0, 0, 400, n);
        n = 0;
        repeat (600) begin
            @(posedge clk_i);
            #1;
            if (sh !== 1'b0) n++;
        end
        check_in(n, 0, 0);
        wr(`APST_A_STAT, 16'h000f);
        $display("stream acq %0d dual %0d done", acq, dual);
    endtask

    initial begin
        rstn_i = 1'b0;
        bus = '0;
        fire_pwm = 1'b0;
        fire_ext = 1'b0;
        level = 8'h00;
        fail_count = 0;
        checked = 0;
        void'($urandom(32'h57c9));
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        rdc(`APST_A_TRIG_EN, `APST_R_TRIG_EN, 16'hffff);
        rdc(`APST_A_STAT, 16'h0000, 16'hffff);
        rdc(4'hf, 16'h0000, 16'hffff);
        check({15'h0000, irq}, 16'h0000);
        wr(`APST_A_SW_TRIG, 16'h0001);
        rdc(`APST_A_STAT, 16'h0008, 16'hffff);
        wr(`APST_A_STAT, 16'h0008);
        wr(`APST_A_CTRL3, 16'h00c0);
        repeat (REF + 10) @(posedge clk_i);
        rdc(`APST_A_PWR, 16'h0001, 16'hffff);
        wr(`APST_A_CTRL3, 16'h00e0);
        fire(1);
        rdc(`APST_A_STAT, 16'h0008, 16'hffff);
        wr(`APST_A_STAT, 16'h0008);
        repeat (CORE + 10) @(posedge clk_i);
        rdc(`APST_A_PWR, 16'h0003, 16'hffff);
        rdc(`APST_A_STAT, 16'h0004, 16'hffff);
        wr(`APST_A_MASK, 16'h0000);
        #1;
        check({15'h0000, irq}, 16'h0000);
        wr(`APST_A_MASK, 16'h0004);
        #1;
        check({15'h0000, irq}, 16'h0001);
        wr(`APST_A_STAT, 16'h0004);
        #1;
        check({15'h0000, irq}, 16'h0000);
        $display("power and interrupt done");
        for (int i = 0; i < 6; i++) begin
            convert(i % 3, (i == 0) ? 0 : (i == 1) ? 15 : int'($urandom_range(15)),
                    i >= 3, int'($urandom_range(i >= 3 ? 7 : 15)));
        end
        stream(int'($urandom_range(3)), 1'b0);
        stream(int'($urandom_range(3)), 1'b1);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        wr(`APST_A_CTRL3, 16'h00e0);
        repeat (REF - 10) @(posedge clk_i);
        rdc(`APST_A_PWR, 16'h0000, 16'hffff);
        repeat (CORE + 30) @(posedge clk_i);
        rdc(`APST_A_PWR, 16'h0003, 16'hffff);
        convert(2, 3, 1'b0, 9);
        results();
    end
endmodule // adc_powerup_and_sample_timing_tb_top

`default_nettype wire
